/* File: hw/led_boost_defs.svh */
`ifndef LED_BOOST_DEFS_SVH
`define LED_BOOST_DEFS_SVH
// Register offsets
`define OFS_LED_OUTPUT_CONTROL      8'h00
`define OFS_COLOR_BRIGHTNESS_SELECT 8'h01
`define OFS_BOOST_VOLTAGE_CODE      8'h0D
`define OFS_BOOST_CONTROL           8'h0E
// Control register fields
`define BIT_INTERNAL_PWM_SELECT     7
`define BIT_COLOR_OUTPUTS_ENABLE    6
`define BIT_SINK_OR_SWITCH_SELECT   5
`define BIT_RED_OUTPUT_ENABLE       3
`define BIT_GREEN_OUTPUT_ENABLE     2
`define BIT_BLUE_OUTPUT_ENABLE      1
`define CTRL_WRITE_MASK             8'hEE
// Colour register fields
`define COLOR_MSB                   7
`define COLOR_LSB                   4
`define BRIGHT_MSB                  3
`define BRIGHT_LSB                  1
`define BIT_OVERLAP_SELECT          0
// Boost control register fields
`define BIT_BOOST_ENABLE            0
// Reset values
`define RST_LED_OUTPUT_CONTROL      8'h20
`define RST_COLOR_BRIGHTNESS_SELECT 8'h00
`define RST_BOOST_VOLTAGE_CODE      8'h08
`define RST_BOOST_CONTROL           8'h00
// Boost voltage code limits
`define BOOST_CODE_MIN              8'h08
`define BOOST_CODE_MAX              8'h14
// Timing
`define CLK_FREQ_HZ                 50000000
`define SOFT_START_MS               20
`define SOFT_START_CYCLES           ((`CLK_FREQ_HZ / 1000) * `SOFT_START_MS)
// PWM frame: 64 brightness steps, 12 colour slices per step
`define PWM_STEPS                   64
`define COLOR_SLICES                12
`endif

/* File: hw/led_boost_pkg.sv */
package led_boost_pkg;
    typedef enum logic [1:0]
    {
        BOOST_STANDBY   = 2'b00,
        BOOST_SOFTSTART = 2'b01,
        BOOST_NORMAL    = 2'b11
    } boost_state_t;
endpackage : led_boost_pkg

/* File: hw/color_duty_table.sv */
`timescale 1ns/100ps
`include "led_boost_defs.svh"
// Maps colour code to red/green/blue slice counts out of 12 slices
module color_duty_table
(
    input  wire logic [3:0] color_code, // Colour code
    output logic      [3:0] red_slices, // Red active slices
    output logic      [3:0] grn_slices, // Green active slices
    output logic      [3:0] blu_slices  // Blue active slices
);
    logic [11:0] row;
    // Twelfths give exact 25/33/50/75/100 percent splits
    always_comb
    begin
        case (color_code)
            4'h0:    row = {4'hC, 4'h0, 4'h0};
            4'h1:    row = {4'h0, 4'hC, 4'h0};
            4'h2:    row = {4'h0, 4'h0, 4'hC};
            4'h3:    row = {4'h6, 4'h6, 4'h0};
            4'h4:    row = {4'h0, 4'h6, 4'h6};
            4'h5:    row = {4'h6, 4'h0, 4'h6};
            4'h6:    row = {4'h4, 4'h4, 4'h4};
            4'h7:    row = {4'h6, 4'h3, 4'h3};
            4'h8:    row = {4'h3, 4'h6, 4'h3};
            4'h9:    row = {4'h3, 4'h6, 4'h3};
            4'hA:    row = {4'h3, 4'h3, 4'h6};
            4'hB:    row = {4'h9, 4'h3, 4'h0};
            4'hC:    row = {4'h0, 4'h9, 4'h3};
            4'hD:    row = {4'h3, 4'h9, 4'h0};
            4'hE:    row = {4'h0, 4'h3, 4'h9};
            default: row = {4'h3, 4'h0, 4'h9};
        endcase
    end
    assign red_slices = row[11:8];
    assign grn_slices = row[7:4];
    assign blu_slices = row[3:0];
endmodule : color_duty_table

/* File: hw/rgb_led_and_boost_control.sv */
`timescale 1ns/100ps
`include "led_boost_defs.svh"
module rgb_led_and_boost_control
#(
    parameter int SOFT_START_CYCLES = `SOFT_START_CYCLES // 20 ms at 50 MHz
)
(
    input  wire logic                         mclk,              // 50 MHz clock
    input  wire logic                         rst_b,             // Async reset, active low
    input  wire logic                         reg_wr,            // Register write strobe
    input  wire logic [7:0]                   reg_addr,          // Register offset
    input  wire logic [7:0]                   reg_wdata,         // Write data
    output logic      [7:0]                   reg_rdata,         // Read data
    output logic                              boost_switching,   // Converter switching allowed
    output logic                              boost_low_current, // Low-current soft-start PWM
    output led_boost_pkg::boost_state_t       boost_state,       // Converter state
    output logic      [7:0]                   boost_target_volts,// Clamped voltage code
    output logic                              switch_mode,       // 1 switch, 0 current sink
    output logic                              red_output_pin,    // Red output on
    output logic                              green_output_pin,  // Green output on
    output logic                              blue_output_pin    // Blue output on
);
    import led_boost_pkg::*;

    localparam int CNT_W = $clog2(SOFT_START_CYCLES + 1);

    logic [7:0]     ctrl_r;
    logic [7:0]     color_r;
    logic [7:0]     vcode_r;
    logic [7:0]     bctl_r;
    boost_state_t   state_r;
    boost_state_t   state_nxt;
    logic [CNT_W-1:0] ss_cnt_r;
    logic [5:0]     step_r;
    logic [3:0]     slice_r;

    // Register decode
    wire wr_ctrl  = reg_wr && (reg_addr == `OFS_LED_OUTPUT_CONTROL);
    wire wr_color = reg_wr && (reg_addr == `OFS_COLOR_BRIGHTNESS_SELECT);
    wire wr_vcode = reg_wr && (reg_addr == `OFS_BOOST_VOLTAGE_CODE);
    wire wr_bctl  = reg_wr && (reg_addr == `OFS_BOOST_CONTROL);

    // Register storage; bits 4 and 0 are masked so they always read zero
    // Boost control stores only the enable; its upper bits stay zero
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r  <= `RST_LED_OUTPUT_CONTROL;
            color_r <= `RST_COLOR_BRIGHTNESS_SELECT;
            vcode_r <= `RST_BOOST_VOLTAGE_CODE;
            bctl_r  <= `RST_BOOST_CONTROL;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= reg_wdata & `CTRL_WRITE_MASK;
            if (wr_color)
                color_r <= reg_wdata;
            if (wr_vcode)
                vcode_r <= reg_wdata;
            if (wr_bctl)
                bctl_r <= {7'h00, reg_wdata[`BIT_BOOST_ENABLE]};
        end
    end

    // Boost control reads back the live state in bits 1:0 instead of the
    // enable bit, so software can poll for the end of soft start
    wire [7:0] bctl_rd = {bctl_r[7:2], state_r};

    // Read mux; unmapped offsets read zero
    assign reg_rdata = (reg_addr == `OFS_LED_OUTPUT_CONTROL)      ? ctrl_r  :
                       (reg_addr == `OFS_COLOR_BRIGHTNESS_SELECT) ? color_r :
                       (reg_addr == `OFS_BOOST_VOLTAGE_CODE)      ? vcode_r :
                       (reg_addr == `OFS_BOOST_CONTROL)           ? bctl_rd :
                       8'h00;

    // Clamp the voltage code; stored value is kept as written
    // so software reads back exactly what it wrote
    wire [7:0] vcode_lo  = (vcode_r < `BOOST_CODE_MIN) ? `BOOST_CODE_MIN : vcode_r;
    wire [7:0] vcode_clp = (vcode_lo > `BOOST_CODE_MAX) ? `BOOST_CODE_MAX : vcode_lo;
    assign boost_target_volts = vcode_clp;

    // Boost sequencer; clearing the enable mid soft start drops straight to
    // standby, and a later enable restarts the full soft-start interval
    wire boost_en = bctl_r[`BIT_BOOST_ENABLE];
    wire ss_done  = (ss_cnt_r == CNT_W'(SOFT_START_CYCLES - 1));
    always_comb
    begin
        case (state_r)
            BOOST_STANDBY:   state_nxt = boost_en ? BOOST_SOFTSTART : BOOST_STANDBY;
            BOOST_SOFTSTART: state_nxt = !boost_en ? BOOST_STANDBY :
                                         (ss_done ? BOOST_NORMAL : BOOST_SOFTSTART);
            BOOST_NORMAL:    state_nxt = boost_en ? BOOST_NORMAL : BOOST_STANDBY;
            default:         state_nxt = BOOST_STANDBY;
        endcase
    end

    // Soft-start counter restarts on every entry to soft start
    // Counting in soft start only keeps the end test a single equality
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r  <= BOOST_STANDBY;
            ss_cnt_r <= '0;
        end
        else
        begin
            state_r  <= state_nxt;
            ss_cnt_r <= (state_r == BOOST_SOFTSTART) ? ss_cnt_r + 1'b1 : '0;
        end
    end

    assign boost_state       = state_r;
    assign boost_switching   = (state_r != BOOST_STANDBY);
    assign boost_low_current = (state_r == BOOST_SOFTSTART);
    assign switch_mode       = ctrl_r[`BIT_SINK_OR_SWITCH_SELECT];

    // PWM timebase: 64 brightness steps, each split into 12 colour slices
    // The frame length is arbitrary here; only ratios are meaningful, so a
    // user who needs a given refresh rate must scale the clock instead
    // Free running: a new colour setting takes effect mid-frame, giving one
    // odd frame but saving a restart path on every register write
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            step_r  <= 6'h00;
            slice_r <= 4'h0;
        end
        else
        begin
            if (slice_r == 4'(`COLOR_SLICES - 1))
            begin
                slice_r <= 4'h0;
                step_r  <= step_r + 6'h01;
            end
            else
                slice_r <= slice_r + 4'h1;
        end
    end

    // Colour ratios
    logic [3:0] red_sl;
    logic [3:0] grn_sl;
    logic [3:0] blu_sl;
    color_duty_table u_duty
    (
        .color_code (color_r[`COLOR_MSB:`COLOR_LSB]),
        .red_slices (red_sl),
        .grn_slices (grn_sl),
        .blu_slices (blu_sl)
    );

    // Brightness window: code b>0 lights the first 2^(b-1) of 64 steps
    wire [2:0] bright = color_r[`BRIGHT_MSB:`BRIGHT_LSB];
    wire [6:0] on_steps = (bright == 3'h0) ? 7'h00 : (7'h01 << (bright - 3'h1));
    wire       bright_on = ({1'b0, step_r} < on_steps);

    // Non-overlapping slots: red, then green, then blue inside each step
    wire [4:0] g_start = {1'b0, red_sl};
    wire [4:0] b_start = {1'b0, red_sl} + {1'b0, grn_sl};
    wire [4:0] b_end   = b_start + {1'b0, blu_sl};
    wire [4:0] sl      = {1'b0, slice_r};
    wire nov_r = (sl < g_start);
    wire nov_g = (sl >= g_start) && (sl < b_start);
    wire nov_b = (sl >= b_start) && (sl < b_end);

    wire overlap = color_r[`BIT_OVERLAP_SELECT];
    wire pwm_r   = bright_on && (overlap || nov_r);
    wire pwm_g   = bright_on && (overlap || nov_g);
    wire pwm_b   = bright_on && (overlap || nov_b);

    // Output selection
    wire en_all   = ctrl_r[`BIT_COLOR_OUTPUTS_ENABLE];
    wire int_pwm  = ctrl_r[`BIT_INTERNAL_PWM_SELECT];
    // Pins are registered, so the hold looks one state ahead: keying it on
    // state_r would leave the pins lit for the first soft-start cycle
    wire hold_off = (state_nxt == BOOST_SOFTSTART);
    wire gate     = en_all && !hold_off;
    wire r_nxt    = gate && ctrl_r[`BIT_RED_OUTPUT_ENABLE]   && (!int_pwm || pwm_r);
    wire g_nxt    = gate && ctrl_r[`BIT_GREEN_OUTPUT_ENABLE] && (!int_pwm || pwm_g);
    wire b_nxt    = gate && ctrl_r[`BIT_BLUE_OUTPUT_ENABLE]  && (!int_pwm || pwm_b);

    // Registered pin drivers avoid glitches from the comparators
    // The cost is one cycle of latency from any register write to the pins
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            red_output_pin   <= 1'b0;
            green_output_pin <= 1'b0;
            blue_output_pin  <= 1'b0;
        end
        else
        begin
            red_output_pin   <= r_nxt;
            green_output_pin <= g_nxt;
            blue_output_pin  <= b_nxt;
        end
    end
endmodule : rgb_led_and_boost_control

/* File: tb/rgb_led_and_boost_control_props.sv */
`timescale 1ns/100ps
`include "led_boost_defs.svh"
// Port-level checks on boost sequencing, code clamping and pin control
module rgb_led_and_boost_control_props
#(
    parameter int SOFT_START_CYCLES = 50 // Soft-start length in cycles
)
(
    input wire logic                        mclk,               // Clock
    input wire logic                        rst_b,              // Reset, active low
    input wire logic                        reg_wr,             // Write strobe
    input wire logic [7:0]                  reg_addr,           // Offset
    input wire logic [7:0]                  reg_rdata,          // Read data
    input wire logic                        boost_switching,    // Switching
    input wire logic                        boost_low_current,  // Soft start PWM
    input wire led_boost_pkg::boost_state_t boost_state,        // State
    input wire logic [7:0]                  boost_target_volts, // Clamped code
    input wire logic                        switch_mode,        // Output type
    input wire logic                        red_output_pin,     // Red pin
    input wire logic                        green_output_pin,   // Green pin
    input wire logic                        blue_output_pin     // Blue pin
);
    import led_boost_pkg::*;
    int         ss_cnt_r;
    logic [7:0] clamp_w;
    logic [2:0] pins_w;
    logic [2:0] en_w;
    // Reference clamp of the read-back code; pins and enables as vectors
    assign clamp_w = (reg_rdata < 8'h08) ? 8'h08 : (reg_rdata > 8'h14) ? 8'h14 : reg_rdata;
    assign pins_w = {red_output_pin, green_output_pin, blue_output_pin};
    assign en_w = reg_rdata[3:1];
    // Soft-start length; a counter, since the count is far above a repetition limit
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            ss_cnt_r <= 0;
        else
            ss_cnt_r <= (boost_state == BOOST_SOFTSTART) ? ss_cnt_r + 1 : 0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_standby; boost_state == BOOST_STANDBY |-> !boost_switching && !boost_low_current; endproperty
    a_standby: assert property (p_standby) else $error("switching in standby");
    property p_low; boost_low_current == (boost_state == BOOST_SOFTSTART); endproperty
    a_low: assert property (p_low) else $error("low-current flag wrong");
    property p_ss_len; boost_state == BOOST_NORMAL && ss_cnt_r != 0 |-> ss_cnt_r == SOFT_START_CYCLES; endproperty
    a_ss_len: assert property (p_ss_len) else $error("soft start length wrong");
    property p_ss_dark; boost_state == BOOST_SOFTSTART |-> pins_w == 3'b000; endproperty
    a_ss_dark: assert property (p_ss_dark) else $error("pin on in soft start");
    property p_clamp; reg_addr == `OFS_BOOST_VOLTAGE_CODE |-> boost_target_volts == clamp_w; endproperty
    a_clamp: assert property (p_clamp) else $error("target not clamped");
    property p_type; reg_addr == 8'h00 |-> switch_mode == reg_rdata[5] && !reg_rdata[4]; endproperty
    a_type: assert property (p_type) else $error("output type or spare bit wrong");
    property p_off; reg_addr == 8'h00 && !reg_wr && !reg_rdata[6] |=> pins_w == 3'b000; endproperty
    a_off: assert property (p_off) else $error("pin on while disabled");
    property p_direct;
        reg_addr == 8'h00 && !reg_wr && reg_rdata[7:6] == 2'b01
        |=> pins_w == ((boost_state == BOOST_SOFTSTART) ? 3'b000 : $past(en_w));
    endproperty
    a_direct: assert property (p_direct) else $error("pins not following enables");
    property p_en; reg_addr == 8'h00 && !reg_wr && !reg_rdata[3] |=> !red_output_pin; endproperty
    a_en: assert property (p_en) else $error("red on while not enabled");
    c_normal: cover property (boost_state == BOOST_NORMAL && ss_cnt_r != 0);
    c_red: cover property ($rose(red_output_pin));
    c_clamp: cover property (reg_addr == 8'h0D && reg_rdata > 8'h14);
endmodule : rgb_led_and_boost_control_props
bind rgb_led_and_boost_control rgb_led_and_boost_control_props #(.SOFT_START_CYCLES(SOFT_START_CYCLES))
    rgb_led_and_boost_control_props_inst (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .boost_switching(boost_switching), .boost_low_current(boost_low_current),
    .boost_state(boost_state), .boost_target_volts(boost_target_volts), .switch_mode(switch_mode),
    .red_output_pin(red_output_pin), .green_output_pin(green_output_pin), .blue_output_pin(blue_output_pin));

/* File: tb/rgb_led_and_boost_control_tb_top.sv */
`timescale 1ns/100ps
module rgb_led_and_boost_control_tb_top;
    import led_boost_pkg::*;
    localparam int SS = 50;
    logic         mclk, rst_b, reg_wr, boost_switching, boost_low_current, switch_mode;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, boost_target_volts;
    logic         red_output_pin, green_output_pin, blue_output_pin;
    boost_state_t boost_state;
    int           n_fail, checks_done, r, g, b, n, on;
    // Slices out of 12 for red, green, blue by colour code
    int rs[16] = '{12, 0, 0, 6, 0, 6, 4, 6, 3, 3, 3, 9, 0, 3, 0, 3};
    int gs[16] = '{0, 12, 0, 6, 6, 0, 4, 3, 6, 6, 3, 3, 9, 9, 3, 0};
    int bs[16] = '{0, 0, 12, 0, 6, 6, 4, 3, 3, 3, 6, 0, 3, 0, 9, 9};
    logic [7:0] cin[7] = '{8'h00, 8'h07, 8'h08, 8'h0E, 8'h14, 8'h15, 8'hFF};
    logic [7:0] cex[7] = '{8'h08, 8'h08, 8'h08, 8'h0E, 8'h14, 8'h14, 8'h14};
    rgb_led_and_boost_control #(.SOFT_START_CYCLES(SS)) rgb_led_and_boost_control_inst
    (
        .mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .boost_switching(boost_switching), .boost_low_current(boost_low_current),
        .boost_state(boost_state), .boost_target_volts(boost_target_volts), .switch_mode(switch_mode),
        .red_output_pin(red_output_pin), .green_output_pin(green_output_pin), .blue_output_pin(blue_output_pin)
    );
    // 50 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge mclk) #1;
        {reg_wr, reg_addr} = 9'h000;
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) #1;
        reg_addr = a;
        #2 chk(nm, {8'h00, e}, {8'h00, reg_rdata});
    endtask : rdc
    // Skips a frame so a new setting is fully in force, then counts on-cycles over one frame
    task automatic frame;
        repeat (770) @(posedge mclk);
        {r, g, b} = 0;
        repeat (768) @(posedge mclk) #1 {r, g, b} = {r + red_output_pin, g + green_output_pin, b + blue_output_pin};
    endtask : frame
    task automatic print_verdict;
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic t_regs;
        rdc("ctrl", 8'h00, 8'h20);
        chk("switch_mode", 16'h1, {15'h0, switch_mode});
        rdc("colour", 8'h01, 8'h00);
        rdc("unmapped", 8'h05, 8'h00);
        chk("state", 16'h0, {14'h0, boost_state});
        wr(8'h00, 8'hFF);
        rdc("ctrl_spare", 8'h00, 8'hEE);
        wr(8'h00, 8'h00);
        chk("switch_mode", 16'h0, {15'h0, switch_mode});
        foreach (cin[i])
        begin
            wr(8'h0D, cin[i]);
            chk("target", {8'h00, cex[i]}, {8'h00, boost_target_volts});
            rdc("vcode_raw", 8'h0D, cin[i]);
        end
    endtask : t_regs
    task automatic t_direct;
        wr(8'h00, 8'h4A);
        repeat (2) @(posedge mclk) #1;
        chk("direct", 16'h5, {13'h0, red_output_pin, green_output_pin, blue_output_pin});
        wr(8'h00, 8'h8E);
        repeat (2) @(posedge mclk) #1;
        chk("disabled", 16'h0, {13'h0, red_output_pin, green_output_pin, blue_output_pin});
    endtask : t_direct
    task automatic t_pwm;
        wr(8'h00, 8'hCA);
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h01, {4'h9, k[2:0], 1'b1});
            frame();
            chk("ovl_red", (k == 0) ? 16'h0 : 16'(12 << (k - 1)), 16'(r));
            chk("ovl_blue", 16'(r), 16'(b));
            chk("ovl_green", 16'h0, 16'(g));
        end
        wr(8'h00, 8'hEE);
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h01, {c[3:0], 4'hE});
            frame();
            chk("slot_red", 16'(rs[c] * 64), 16'(r));
            chk("slot_green", 16'(gs[c] * 64), 16'(g));
            chk("slot_blue", 16'(bs[c] * 64), 16'(b));
        end
    endtask : t_pwm
    task automatic t_boost;
        wr(8'h00, 8'h4E);
        wr(8'h0E, 8'h01);
        // The state follows the enable one edge after the write lands
        @(posedge mclk) #1;
        chk("low_current", 16'h3, {14'h0, boost_low_current, boost_switching});
        {n, on} = {32'd1, 29'd0, red_output_pin, green_output_pin, blue_output_pin};
        while (boost_state == BOOST_SOFTSTART && n < SS + 10)
        begin
            @(posedge mclk) #1;
            if (boost_state == BOOST_SOFTSTART)
            begin
                n++;
                on = on | red_output_pin | green_output_pin | blue_output_pin;
            end
        end
        if (n >= SS + 10)
        begin
            n_fail++;
            print_verdict();
        end
        chk("soft_len", 16'(SS), 16'(n));
        chk("soft_dark", 16'h0, 16'(on));
        chk("normal", 16'h3, {14'h0, boost_state});
        chk("lit", 16'h7, {13'h0, red_output_pin, green_output_pin, blue_output_pin});
        rdc("boost_rd", 8'h0E, 8'h03);
        wr(8'h0E, 8'h00);
        @(posedge mclk) #1;
        chk("stop", 16'h0, {13'h0, boost_state, boost_switching});
        // Enable then clear at once, so the clear lands inside soft start
        wr(8'h0E, 8'h01);
        wr(8'h0E, 8'h00);
        @(posedge mclk) #1;
        chk("abort", 16'h0, {13'h0, boost_state, boost_switching});
    endtask : t_boost
    // Reset for six cycles, then each scenario in turn
    initial
    begin
        {rst_b, reg_wr, reg_addr, reg_wdata, n_fail, checks_done} = 0;
        repeat (6) @(posedge mclk);
        #1 rst_b = 1'b1;
        t_regs();
        t_direct();
        t_pwm();
        t_boost();
        print_verdict();
    end
endmodule : rgb_led_and_boost_control_tb_top
